// ### rgd_pkg.sv
package rgd_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    // System clock period in nanoseconds (50 MHz).
    localparam int MCLK_PERIOD_NS = 20;
    // Receive clock half periods in nanoseconds for 1000, 100 and 10 Mbps.
    localparam int RXC_HALF_G_NS   = 4;
    localparam int RXC_HALF_100_NS = 20;
    localparam int RXC_HALF_10_NS  = 200;
    // Half periods in system cycles, rounded down, never below one.
    localparam int RXC_HALF_G_CYC   = (RXC_HALF_G_NS / MCLK_PERIOD_NS) < 1 ? 1 : RXC_HALF_G_NS / MCLK_PERIOD_NS;
    localparam int RXC_HALF_100_CYC = (RXC_HALF_100_NS / MCLK_PERIOD_NS) < 1 ? 1 : RXC_HALF_100_NS / MCLK_PERIOD_NS;
    localparam int RXC_HALF_10_CYC  = (RXC_HALF_10_NS / MCLK_PERIOD_NS) < 1 ? 1 : RXC_HALF_10_NS / MCLK_PERIOD_NS;
    // Width of the receive clock divider counter.
    localparam int RXC_CNT_W = 8;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    // Number of media pairs and width of one media symbol.
    localparam int NUM_PAIRS = 4;
    localparam int SYM_W     = 8;
    // Depth of the receive-path buffer.
    localparam int RXBUF_DEPTH = 2;
    // Reset level of a media symbol and of the receive data lines.
    localparam logic [SYM_W-1:0] SYM_RST = 8'h00;
    localparam logic [3:0]       NIB_RST = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Operating speed of the link.
    typedef enum logic [1:0] {
        RGD_SPD_10,
        RGD_SPD_100,
        RGD_SPD_1000,
        RGD_SPD_RSVD
    } rgd_speed_t;

    // One byte with its error mark, as carried in the data path.
    typedef struct packed {
        logic [7:0] data;
        logic       err;
    } rgd_word_t;

    // Symbols on the four media pairs or four channels.
    typedef logic [NUM_PAIRS-1:0][SYM_W-1:0] rgd_syms_t;

endpackage

// ### rgd_datapath.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Rising transmit edge control is frame valid.
// - Falling transmit edge control decodes error.
// - Gigabit transmit: low nibble rise, high fall.
// - Slow modes: one transmit nibble per rise.
// - Device makes receive clock per speed.
// - Receive control carries valid on rise.
// - Receive control carries derived value on fall.
// - Gigabit receive: low nibble rise, high fall.
// - Slow modes: one receive nibble per period.
// - Gigabit pairs map A-D, crossed swaps pairs.
// - Slow modes: straight transmit pair zero, receive one.
// - Slow modes leave pairs two, three idle.
module rgd_datapath
    import rgd_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Configuration.
    input  wire rgd_speed_t            speed,
    input  wire logic                  mdix,
    // RGMII transmit side, driven by the MAC.
    input  wire logic                  tx_clk,
    input  wire logic                  tx_ctl,
    input  wire logic [3:0]            txd,
    // RGMII receive side, driven toward the MAC.
    output logic                       rx_clk,
    output logic                       rx_ctl,
    output logic [3:0]                 rxd,
    // Transmit bytes decoded from the MAC.
    output rgd_word_t                  tx_word,
    output logic                       tx_word_valid,
    output logic                       tx_frame,
    // Receive bytes from the line toward the MAC.
    input  wire rgd_word_t             rx_word,
    input  wire logic                  rx_word_valid,
    output logic                       rx_word_ready,
    // Channel symbols A to D on the coding side.
    input  wire rgd_syms_t             chan_tx,
    output rgd_syms_t                  chan_rx,
    // Media pairs zero to three: input, output and active-low enable.
    input  wire rgd_syms_t             media_pair_i,
    output rgd_syms_t                  media_pair_o,
    output logic [NUM_PAIRS-1:0]       media_pair_oe_n
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // All state of the block in one record.
    typedef struct packed {
        logic                               txc_prev;   // Last sampled transmit clock.
        logic                               tx_en;      // Frame valid from rising edge.
        logic [3:0]                         tx_lo;      // Low nibble awaiting its partner.
        logic                               tx_half;    // Slow modes: low nibble held.
        rgd_word_t                          tx_out;     // Decoded transmit byte.
        logic                               tx_out_v;   // One-cycle byte strobe.
        logic [RXC_CNT_W-1:0]               rxc_cnt;    // Receive clock divider.
        logic                               rxc;        // Receive clock level.
        logic                               rx_dv;      // Byte on the receive lines is valid.
        rgd_word_t                          rx_cur;     // Byte on the receive lines.
        logic                               rx_half;    // Slow modes: high nibble next.
        logic                               rx_ctl;     // Receive control line.
        logic [3:0]                         rxd;        // Receive data lines.
        logic [RXBUF_DEPTH-1:0][$bits(rgd_word_t)-1:0] buf_mem; // Buffer entries.
        logic                               buf_head;   // Oldest entry index.
        logic [1:0]                         buf_cnt;    // Entries held.
        rgd_syms_t                          pair_o;     // Media pair outputs.
        logic [NUM_PAIRS-1:0]               pair_oe_n;  // Media pair enables.
        rgd_syms_t                          chan_rx;    // Channel receive symbols.
    } rgd_state_t;

    rgd_state_t st_q;   // Registered state.
    rgd_state_t st_d;   // Next state.

    // ----------------------------------------------------------------
    // Combinational helpers
    // ----------------------------------------------------------------
    logic                 gig;          // Gigabit mode.
    logic                 txc_rise;     // Rising transmit clock seen.
    logic                 txc_fall;     // Falling transmit clock seen.
    logic [RXC_CNT_W-1:0] rxc_half;     // Half period for the current speed.
    logic                 rxc_tick;     // Receive clock toggles this cycle.
    logic                 buf_pop;      // Receive serialiser takes a byte.
    logic                 buf_push;     // Line side delivers a byte.
    rgd_word_t            buf_front;    // Oldest buffer entry.
    rgd_syms_t            pair_map_o;   // Pair outputs before registering.
    rgd_syms_t            chan_map_rx;  // Channel inputs before registering.
    logic [NUM_PAIRS-1:0] pair_map_oe_n; // Pair enables before registering.

    assign gig = (speed == RGD_SPD_1000);

    // Transmit clock is sampled; its edges pace capture.
    assign txc_rise = tx_clk & ~st_q.txc_prev;
    assign txc_fall = ~tx_clk & st_q.txc_prev;

    // Divider picks receive clock rate from speed.
    always_comb begin
        case (speed)
            RGD_SPD_1000: begin
                rxc_half = RXC_CNT_W'(RXC_HALF_G_CYC);
            end
            RGD_SPD_100: begin
                rxc_half = RXC_CNT_W'(RXC_HALF_100_CYC);
            end
            default: begin
                rxc_half = RXC_CNT_W'(RXC_HALF_10_CYC);
            end
        endcase
    end
    assign rxc_tick = (st_q.rxc_cnt >= rxc_half - 1'b1);

    // The buffer accepts a byte while it has a free entry and the block runs.
    // A handshake taken while the clock enable is low would lose the word.
    assign rx_word_ready = ce & (st_q.buf_cnt < 2'(RXBUF_DEPTH));
    assign buf_push      = rx_word_valid & rx_word_ready;
    assign buf_front     = rgd_word_t'(st_q.buf_mem[st_q.buf_head]);
    // A new byte is needed at a rising edge unless the high nibble is due.
    assign buf_pop       = rxc_tick & ~st_q.rxc & (gig | ~st_q.rx_half) & (st_q.buf_cnt != 2'd0);

    // ----------------------------------------------------------------
    // Media pair mapping, one slice per pair
    // ----------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
            // Channel paired with this media pair in gigabit mode.
            localparam int STRAIGHT = gp;
            localparam int CROSSED  = gp ^ 1;
            always_comb begin
                if (gig) begin
                    // Straight or swapped channel per pair.
                    pair_map_o[gp]    = mdix ? chan_tx[CROSSED] : chan_tx[STRAIGHT];
                    chan_map_rx[gp]   = mdix ? media_pair_i[CROSSED] : media_pair_i[STRAIGHT];
                    pair_map_oe_n[gp] = 1'b0;
                end else if (gp < 2) begin
                    // Transmit pair is zero straight, one crossed.
                    pair_map_oe_n[gp] = ((gp == 0) == mdix);
                    pair_map_o[gp]    = pair_map_oe_n[gp] ? SYM_RST : chan_tx[0];
                    // Channel A takes the receive pair; channel B idles.
                    chan_map_rx[gp]   = (gp == 0) ? media_pair_i[mdix ? 0 : 1] : SYM_RST;
                end else begin
                    // Pairs two and three stay undriven.
                    pair_map_o[gp]    = SYM_RST;
                    pair_map_oe_n[gp] = 1'b1;
                    chan_map_rx[gp]   = SYM_RST;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Computes every state field from the current state and inputs.
    always_comb begin
        st_d          = st_q;
        st_d.txc_prev = tx_clk;
        st_d.tx_out_v = 1'b0;
        st_d.pair_o    = pair_map_o;
        st_d.pair_oe_n = pair_map_oe_n;
        st_d.chan_rx   = chan_map_rx;

        // Transmit capture on the rising edge.
        if (txc_rise) begin
            // Control on rise is frame valid.
            st_d.tx_en = tx_ctl;
            if (!tx_ctl) begin
                // Frame over: restart nibble pairing.
                st_d.tx_half = 1'b0;
            end else if (gig || !st_q.tx_half) begin
                st_d.tx_lo   = txd;
                st_d.tx_half = ~gig;
            end else begin
                // Second nibble of a slow-mode byte.
                st_d.tx_out.data = {txd, st_q.tx_lo};
                st_d.tx_out_v    = 1'b1;
                st_d.tx_half     = 1'b0;
            end
        end

        // Transmit capture on the falling edge.
        if (txc_fall && st_q.tx_en) begin
            st_d.tx_out.err = st_q.tx_en ^ tx_ctl;
            if (gig) begin
                st_d.tx_out.data = {txd, st_q.tx_lo};
                st_d.tx_out_v    = 1'b1;
            end
        end

        // Receive clock divider.
        if (rxc_tick) begin
            st_d.rxc_cnt = '0;
            st_d.rxc     = ~st_q.rxc;
        end else begin
            st_d.rxc_cnt = st_q.rxc_cnt + 1'b1;
        end

        // Receive drive at the rising edge.
        if (rxc_tick && !st_q.rxc) begin
            if (gig || !st_q.rx_half) begin
                st_d.rx_dv  = buf_pop;
                st_d.rx_cur = buf_pop ? buf_front : st_q.rx_cur;
                // Low nibble rides the rising edge.
                st_d.rxd     = buf_pop ? buf_front.data[3:0] : NIB_RST;
                st_d.rx_half = ~gig & buf_pop;
            end else begin
                // High nibble in the next period.
                st_d.rxd     = st_q.rx_cur.data[7:4];
                st_d.rx_half = 1'b0;
            end
            st_d.rx_ctl = (gig || !st_q.rx_half) ? buf_pop : st_q.rx_dv;
        end

        // Receive drive at the falling edge.
        if (rxc_tick && st_q.rxc) begin
            // Derived value on the falling edge.
            st_d.rx_ctl = st_q.rx_dv ^ (st_q.rx_dv & st_q.rx_cur.err);
            if (gig && st_q.rx_dv) begin
                // High nibble rides the falling edge.
                st_d.rxd = st_q.rx_cur.data[7:4];
            end
        end

        // Two-entry buffer bookkeeping.
        if (buf_push) begin
            st_d.buf_mem[st_q.buf_head ^ st_q.buf_cnt[0]] = rx_word;
        end
        if (buf_pop) begin
            st_d.buf_head = ~st_q.buf_head;
        end
        st_d.buf_cnt = st_q.buf_cnt + 2'(buf_push) - 2'(buf_pop);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Holds all state; the clock enable freezes it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q           <= '0;
            st_q.pair_oe_n <= '1;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rx_clk          = st_q.rxc;
    assign rx_ctl          = st_q.rx_ctl;
    assign rxd             = st_q.rxd;
    assign tx_word         = st_q.tx_out;
    assign tx_word_valid   = st_q.tx_out_v;
    assign tx_frame        = st_q.tx_en;
    assign chan_rx         = st_q.chan_rx;
    assign media_pair_o    = st_q.pair_o;
    assign media_pair_oe_n = st_q.pair_oe_n;

endmodule

// ### rgd_datapath_props.sv
`timescale 1ns/1ns
module rgd_datapath_props
    import rgd_pkg::*;
(
    // Clock, reset and configuration.
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire rgd_speed_t           speed,
    input wire logic                 mdix,
    // Transmit and receive lines.
    input wire logic                 tx_clk,
    input wire logic                 tx_ctl,
    input wire logic                 tx_word_valid,
    input wire logic                 tx_frame,
    input wire logic                 rx_clk,
    input wire logic                 rx_ctl,
    input wire logic [3:0]           rxd,
    input wire logic                 rx_word_ready,
    // Channels and media pairs.
    input wire rgd_syms_t            chan_tx,
    input wire rgd_syms_t            chan_rx,
    input wire rgd_syms_t            media_pair_i,
    input wire rgd_syms_t            media_pair_o,
    input wire logic [NUM_PAIRS-1:0] media_pair_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_gig_oe: assert property (rst_n && ce && speed == RGD_SPD_1000 |=> media_pair_oe_n == 4'h0)
        else $error("pairs idle in gigabit");
    chk_gig_map: assert property (ce && speed == RGD_SPD_1000 |=>
        media_pair_o[0] == ($past(mdix) ? $past(chan_tx[1]) : $past(chan_tx[0]))
        && chan_rx[1] == ($past(mdix) ? $past(media_pair_i[0]) : $past(media_pair_i[1])))
        else $error("gigabit pair map wrong");
    chk_slow_idle: assert property (ce && speed != RGD_SPD_1000 |=>
        media_pair_oe_n[3:2] == 2'h3 && media_pair_o[2] == 8'h00)
        else $error("upper pairs busy in slow mode");
    chk_slow_tx: assert property (ce && speed != RGD_SPD_1000 && !mdix |=>
        !media_pair_oe_n[0] && media_pair_o[0] == $past(chan_tx[0]))
        else $error("slow transmit pair wrong");
    chk_slow_rx: assert property (ce && speed != RGD_SPD_1000 |=>
        chan_rx[0] == ($past(mdix) ? $past(media_pair_i[0]) : $past(media_pair_i[1])))
        else $error("slow receive pair wrong");
    chk_rxclk_gig: assert property (ce && speed == RGD_SPD_1000
        && $past(speed) == RGD_SPD_1000 && $rose(rx_clk) |=> $fell(rx_clk))
        else $error("receive clock half wrong");
    chk_rx_sync: assert property ($changed(rxd) || $changed(rx_ctl) |-> $changed(rx_clk))
        else $error("receive lines move off clock edge");
    chk_txv_pulse: assert property (tx_word_valid |=> !tx_word_valid)
        else $error("byte strobe too long");
    chk_frame_end: assert property (ce && $rose(tx_clk) && !tx_ctl |-> ##[1:3] !tx_frame)
        else $error("frame did not end");

    cover property (tx_word_valid);
    cover property (!rx_word_ready);
    cover property ($rose(rx_clk) && rx_ctl);
endmodule

bind rgd_datapath rgd_datapath_props u_props (.mclk(mclk), .rst_n(rst_n), .ce(ce), .speed(speed),
    .mdix(mdix), .tx_clk(tx_clk), .tx_ctl(tx_ctl), .tx_word_valid(tx_word_valid),
    .tx_frame(tx_frame), .rx_clk(rx_clk), .rx_ctl(rx_ctl), .rxd(rxd), .rx_word_ready(rx_word_ready),
    .chan_tx(chan_tx), .chan_rx(chan_rx), .media_pair_i(media_pair_i),
    .media_pair_o(media_pair_o), .media_pair_oe_n(media_pair_oe_n));

// ### rgd_mac_model.sv
`timescale 1ns/1ns
module rgd_mac_model (
    // Clock.
    input  wire logic  mclk,
    // Transmit lines toward the device.
    output logic       tx_clk,
    output logic       tx_ctl,
    output logic [3:0] txd
);
    // Clock stands low until a frame starts.
    initial begin
        tx_clk = 1'b0;
        tx_ctl = 1'b0;
        txd    = 4'h0;
    end
    // One clock phase, launched just after a system edge.
    task automatic phase(input logic c, input logic k, input logic [3:0] d);
        @(posedge mclk);
        tx_clk <= c;
        tx_ctl <= k;
        txd    <= d;
    endtask
    task automatic send(input logic [7:0] b, input logic e, input logic gig);
        if (gig) begin
            phase(1'b1, 1'b1, b[3:0]);
            phase(1'b0, ~e, b[7:4]);
        end else begin
            phase(1'b1, 1'b1, b[3:0]);
            phase(1'b0, ~e, ~b[3:0]);
            phase(1'b1, 1'b1, b[7:4]);
            phase(1'b0, ~e, ~b[7:4]);
        end
    endtask
    // frame end: a rise with control low, data lines garbled.
    task automatic idle();
        phase(1'b1, 1'b0, ~txd);
        phase(1'b0, 1'b0, txd);
    endtask
endmodule

// ### rgd_datapath_bench.sv
`timescale 1ns/1ns
module rgd_datapath_bench
    import rgd_pkg::*;
;
    logic                 mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, mdix = 1'b0, rx_word_valid = 1'b0;
    rgd_speed_t           speed = RGD_SPD_1000;
    logic                 tx_clk, tx_ctl, rx_clk, rx_ctl, tx_word_valid, tx_frame, rx_word_ready;
    logic [3:0]           txd, rxd, lo;
    rgd_word_t            tx_word, rx_word = '0;
    rgd_syms_t            chan_tx = '0, chan_rx, media_pair_i = '0, media_pair_o;
    logic [NUM_PAIRS-1:0] media_pair_oe_n;
    logic                 rc_q = 1'b0, er = 1'b0, half = 1'b0, full_seen = 1'b0;
    int                   error_cnt = 0, check_count = 0, run = 0, last_half = 0;
    rgd_word_t            txq[$], rxq[$];

    always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

    rgd_datapath uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .speed(speed), .mdix(mdix),
        .tx_clk(tx_clk), .tx_ctl(tx_ctl), .txd(txd), .rx_clk(rx_clk), .rx_ctl(rx_ctl), .rxd(rxd),
        .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_frame(tx_frame), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready), .chan_tx(chan_tx),
        .chan_rx(chan_rx), .media_pair_i(media_pair_i), .media_pair_o(media_pair_o),
        .media_pair_oe_n(media_pair_oe_n));
    rgd_mac_model mac (.mclk(mclk), .tx_clk(tx_clk), .tx_ctl(tx_ctl), .txd(txd));

    // Collects bytes on both sides and rebuilds received bytes from the lines.
    always @(posedge mclk) begin
        rc_q <= rx_clk;
        run  <= (rx_clk !== rc_q) ? 1 : run + 1;
        if (rx_clk !== rc_q) last_half <= run;
        if (tx_word_valid === 1'b1) txq.push_back(tx_word);
        if (rx_word_ready === 1'b0) full_seen <= 1'b1;
        if (rx_clk === 1'b1 && rc_q === 1'b0) begin
            if (rx_ctl !== 1'b1) half <= 1'b0;
            else if (speed == RGD_SPD_1000 || !half) begin
                lo   <= rxd;
                half <= 1'b1;
            end else begin
                rxq.push_back({rxd, lo, er});
                half <= 1'b0;
            end
        end
        if (rx_clk === 1'b0 && rc_q === 1'b1) begin
            er <= ~rx_ctl;
            if (speed == RGD_SPD_1000 && half) begin
                rxq.push_back({rxd, lo, ~rx_ctl});
                half <= 1'b0;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Every speed and crossing setting against the pair map.
    task automatic t_map();
        for (int s = 0; s < 4; s++) begin
            for (int m = 0; m < 2; m++) begin
                @(posedge mclk);
                speed        <= rgd_speed_t'(s);
                mdix         <= m[0];
                chan_tx      <= 32'h44332211 ^ {4{8'(s * 16 + m)}};
                media_pair_i <= 32'hD4C3B2A1 ^ {4{8'(m * 16 + s)}};
                @(posedge mclk);
                @(negedge mclk);
                if (s == 2) begin
                    check(media_pair_oe_n, 32'h0);
                    for (int p = 0; p < 4; p++) begin
                        check(media_pair_o[p], chan_tx[p ^ m]);
                        check(chan_rx[p], media_pair_i[p ^ m]);
                    end
                end else begin
                    check(media_pair_o[m], chan_tx[0]);
                    check(media_pair_oe_n[m], 32'h0);
                    check({media_pair_oe_n[1 - m], media_pair_o[1 - m]}, 32'h100);
                    check(chan_rx[0], media_pair_i[1 - m]);
                    check(chan_rx[3:1], 32'h0);
                    check({media_pair_oe_n[3:2], media_pair_o[3:2]}, 32'h30000);
                end
            end
        end
    endtask

    // A frame of three bytes, the middle one marked bad.
    task automatic t_tx(input rgd_speed_t s);
        @(posedge mclk);
        speed <= s;
        txq.delete();
        for (int i = 0; i < 3; i++) mac.send(8'(8'h5A + 8'h37 * i), i == 1, s == RGD_SPD_1000);
        @(negedge mclk);
        check(tx_frame, 32'h1);
        mac.idle();
        repeat (4) @(negedge mclk);
        check(tx_frame, 32'h0);
        check(txq.size(), 32'h3);
        for (int i = 0; i < 3; i++) check(txq[i], {8'(8'h5A + 8'h37 * i), 1'(i == 1)});
    endtask

    task automatic push(input rgd_word_t w);
        rx_word       <= w;
        rx_word_valid <= 1'b1;
        @(negedge mclk);
        while (rx_word_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
    endtask

    // Four bytes back to back from the line side toward the MAC.
    task automatic t_rx(input rgd_speed_t s);
        @(posedge mclk);
        speed     <= s;
        full_seen <= 1'b0;
        repeat (4) @(posedge mclk);
        rxq.delete();
        for (int i = 0; i < 4; i++) push({8'(8'hA6 + 8'h29 * i), 1'(i == 2)});
        rx_word_valid <= 1'b0;
        for (int k = 0; k < 400 && rxq.size() < 4; k++) @(posedge mclk);
        check(rxq.size(), 32'h4);
        for (int i = 0; i < 4; i++) check(rxq[i], {8'(8'hA6 + 8'h29 * i), 1'(i == 2)});
        check(full_seen, 32'h1);
        if (s == RGD_SPD_10) begin
            check(last_half, 32'd10);
        end else begin
            check(last_half, 32'd1);
        end
    endtask

    // Cuts a hang short.
    initial begin
        #(MCLK_PERIOD_NS * 20000);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_map();
        t_tx(RGD_SPD_1000);
        t_tx(RGD_SPD_100);
        t_rx(RGD_SPD_1000);
        t_rx(RGD_SPD_100);
        t_rx(RGD_SPD_10);
        results();
    end
endmodule
